// ### bench/bfss_analog_model.sv
// Analog sense, supply lockout and output-ok pull-up around the block
`timescale 1ns/1ps
`default_nettype none
module bfss_analog_model (
    input wire logic [11:0] fb_mv, // Feedback mV
    input wire logic [11:0] avin_mv, // Supply mV
    input wire logic [8:0] temp_c, // Junction C
    input wire logic [13:0] valley_ma, // Valley mA
    input wire logic [7:0] ramp, // Ramp code
    input wire logic pg_o, // Pin value
    input wire logic pg_oe_b, // Pin drive
    output logic supply_ok, // Lockout
    output logic below_uv, // Low fb
    output logic above_ov, // High fb
    output logic at_ref, // Exit level
    output logic above_ramp, // Pre-bias
    output logic over_limit, // Valley
    output logic hot, // Hot
    output logic cool, // Cool
    output logic in_win, // Window
    output logic pin // Pin level
);
    assign supply_ok = avin_mv > 12'h9f6;
    assign below_uv = fb_mv < 12'h1c2;
    // 121 percent of 600 mV
    assign above_ov = fb_mv > 12'h2d6;
    assign at_ref = fb_mv <= 12'h258;
    // Code 255 stands for the full 600 mV reference
    assign above_ramp = 20'(fb_mv) * 20'h000ff > 20'(ramp) * 20'h00258;
    assign over_limit = valley_ma > 14'h1d4c;
    assign hot = temp_c > 9'h0a0;
    assign cool = temp_c < 9'h082;
    // Window edges are arbitrary, 540 to 660 mV
    assign in_win = fb_mv >= 12'h21c && fb_mv <= 12'h294;
    // Released pin rises to the board pull-up
    assign pin = pg_oe_b ? 1'b1 : pg_o;
endmodule : bfss_analog_model
`default_nettype wire

// ### bench/bfss_top_bench.sv
// Self-checking bench for the start-up and fault supervisor
`timescale 1ns/1ps
`default_nettype none
module bfss_top_bench;
    // Short ramp, 8 cycles a step
    localparam int SS_CYC = 2048;
    logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, irq, hs_request = 1'b1, enable_pin = 1'b0;
    logic supply_ok, below_uv, above_ov, at_ref, above_ramp, over_limit;
    logic hot, cool, in_win, hs, ls, pin, pg_o, pg_oe_b;
    logic [7:0] ramp;
    logic [11:0] fb_mv = 12'h258, avin_mv = 12'hce4;
    logic [8:0] temp_c = 9'h019;
    logic [13:0] valley_ma = 14'h1388;
    int failures = 0, samples_checked = 0;
    always #12.5 clk = ~clk;
    bfss_top #(.SS_CYC(SS_CYC), .UV_TRIP_EN(1'b1)) uut (
        .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq),
        .logic_supply_ok(supply_ok), .enable_pin(enable_pin),
        .fb_below_uv(below_uv), .fb_above_ov(above_ov), .fb_at_ref(at_ref),
        .fb_above_ramp(above_ramp), .valley_over_limit(over_limit),
        .temp_hot(hot), .temp_cool(cool), .fb_in_window(in_win),
        .hs_request(hs_request), .high_side_switch(hs),
        .low_side_switch(ls), .soft_start_ref(ramp), .output_ok_i(pin),
        .output_ok_o(pg_o), .output_ok_oe_b(pg_oe_b));
    bfss_analog_model model (
        .fb_mv(fb_mv), .avin_mv(avin_mv), .temp_c(temp_c),
        .valley_ma(valley_ma), .ramp(ramp), .pg_o(pg_o), .pg_oe_b(pg_oe_b),
        .supply_ok(supply_ok), .below_uv(below_uv), .above_ov(above_ov),
        .at_ref(at_ref), .above_ramp(above_ramp), .over_limit(over_limit),
        .hot(hot), .cool(cool), .in_win(in_win), .pin(pin));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("Compared %0d, mismatched %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic fb(input logic [11:0] v, input int n);
        @(posedge clk);
        fb_mv <= v;
        cyc(n);
    endtask : fb
    task automatic sw(input logic h, input logic l);
        check({hs, ls}, {h, l});
    endtask : sw
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(negedge clk);
    endtask : bus
    task automatic wait_top(output int n);
        for (n = 0; n < 4000 && ramp !== 8'hff; n++) @(negedge clk);
    endtask : wait_top
    task automatic t_reset();
        cyc(1);
        check({hs, ls, ramp, pg_oe_b, irq}, 12'h000);
        bus(1'b1, 4'h2, 32'hffffffff);
        bus(1'b0, bfss_pkg::REG_MASK, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, bfss_pkg::REG_CTRL, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, bfss_pkg::REG_STATE, 32'h0);
        check(rd[17:0], {12'h000, bfss_pkg::ST_IDLE});
        $display("reset test done");
    endtask : t_reset
    task automatic t_soft();
        int n;
        @(posedge clk);
        fb_mv <= 12'h064;
        enable_pin <= 1'b1;
        cyc(40);
        sw(1'b0, 1'b0);
        cyc(600);
        sw(1'b1, 1'b0);
        @(posedge clk);
        valley_ma <= 14'h1f40;
        cyc(10);
        sw(1'b0, 1'b1);
        @(posedge clk);
        valley_ma <= 14'h1388;
        fb_mv <= 12'h320;
        cyc(10);
        sw(1'b0, 1'b0);
        fb(12'h064, 0);
        wait_top(n);
        check(n + 685 >= 2040 && n + 685 <= 2090, 1'b1);
        fb(12'h258, 10);
        sw(1'b1, 1'b0);
        bus(1'b0, bfss_pkg::REG_STATE, 32'h0);
        check(rd[5:0], bfss_pkg::ST_RUN);
        bus(1'b0, bfss_pkg::REG_STATUS, 32'h0);
        check({rd[bfss_pkg::EV_SS], rd[bfss_pkg::EV_UV]}, 2'b10);
        $display("soft test done");
    endtask : t_soft
    task automatic t_ov();
        fb(12'h320, 10);
        sw(1'b0, 1'b1);
        check(pg_oe_b, 1'b0);
        fb(12'h2bc, 10);
        sw(1'b0, 1'b1);
        fb(12'h258, 10);
        sw(1'b1, 1'b0);
        check({pg_oe_b, pin}, 2'b11);
        bus(1'b0, bfss_pkg::REG_STATUS, 32'h0);
        check(rd[bfss_pkg::EV_OV], 1'b1);
        $display("ov test done");
    endtask : t_ov
    task automatic t_uv();
        int n;
        bus(1'b1, bfss_pkg::REG_MASK, 32'h1);
        bus(1'b0, bfss_pkg::REG_STATUS, 32'h0);
        check(irq, 1'b0);
        fb(12'h064, 780);
        sw(1'b1, 1'b0);
        fb(12'h258, 20);
        fb(12'h064, 790);
        sw(1'b1, 1'b0);
        cyc(30);
        sw(1'b0, 1'b0);
        check(irq, 1'b1);
        fb(12'h258, 20);
        sw(1'b0, 1'b0);
        bus(1'b0, bfss_pkg::REG_STATE, 32'h0);
        check(rd[5:0], bfss_pkg::ST_UVL);
        bus(1'b0, bfss_pkg::REG_STATUS, 32'h0);
        check(rd[bfss_pkg::EV_UV], 1'b1);
        cyc(2);
        check(irq, 1'b0);
        bus(1'b1, bfss_pkg::REG_MASK, 32'h0);
        @(posedge clk);
        enable_pin <= 1'b0;
        cyc(10);
        bus(1'b0, bfss_pkg::REG_STATE, 32'h0);
        check(rd[5:0], bfss_pkg::ST_IDLE);
        @(posedge clk);
        enable_pin <= 1'b1;
        wait_top(n);
        cyc(10);
        sw(1'b1, 1'b0);
        $display("uv test done");
    endtask : t_uv
    task automatic t_therm();
        int n;
        @(posedge clk);
        temp_c <= 9'h0aa;
        cyc(10);
        check({hs, ls, ramp}, 10'h000);
        @(posedge clk);
        temp_c <= 9'h08c;
        cyc(40);
        check(ramp, 8'h00);
        @(posedge clk);
        temp_c <= 9'h078;
        cyc(40);
        check(ramp != 8'h00, 1'b1);
        wait_top(n);
        @(posedge clk);
        avin_mv <= 12'h7d0;
        cyc(10);
        check({hs, ls, ramp}, 10'h000);
        @(posedge clk);
        avin_mv <= 12'hce4;
        wait_top(n);
        bus(1'b1, bfss_pkg::REG_CTRL, 32'h1);
        cyc(10);
        check({hs, ls, ramp}, 10'h000);
        bus(1'b1, bfss_pkg::REG_CTRL, 32'h0);
        $display("therm test done");
    endtask : t_therm
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_soft();
        t_ov();
        t_uv();
        t_therm();
        test_done();
    end
    initial begin
        #(25 * 40000);
        failures++;
        test_done();
    end
endmodule : bfss_top_bench
bind bfss_top bfss_top_properties #(.UV_TRIP_EN(UV_TRIP_EN)) chk (
    .clk(clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .logic_supply_ok(logic_supply_ok),
    .enable_pin(enable_pin), .fb_below_uv(fb_below_uv),
    .fb_above_ov(fb_above_ov), .fb_above_ramp(fb_above_ramp),
    .valley_over_limit(valley_over_limit), .temp_hot(temp_hot),
    .fb_in_window(fb_in_window), .high_side_switch(high_side_switch),
    .low_side_switch(low_side_switch), .soft_start_ref(soft_start_ref),
    .output_ok_o(output_ok_o), .output_ok_oe_b(output_ok_oe_b));
`default_nettype wire

// ### bench/bfss_top_properties.sv
// Port-level concurrent checks for the supervisor
`timescale 1ns/1ps
`default_nettype none
module bfss_top_properties #(
    parameter bit UV_TRIP_EN = 1'b1
) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic avs_waitrequest, // Stall
    input wire logic logic_supply_ok, // Supply
    input wire logic enable_pin, // Enable
    input wire logic fb_below_uv, // Low fb
    input wire logic fb_above_ov, // High fb
    input wire logic fb_above_ramp, // Pre-bias
    input wire logic valley_over_limit, // Valley
    input wire logic temp_hot, // Hot
    input wire logic fb_in_window, // Window
    input wire logic high_side_switch, // High
    input wire logic low_side_switch, // Low
    input wire logic [bfss_pkg::RAMP_W-1:0] soft_start_ref, // Ramp
    input wire logic output_ok_o, // Pin value
    input wire logic output_ok_oe_b // Pin drive
);
    // 800 cycles plus sync and register latency
    localparam int UV_LIM = 812;
    logic [10:0] uv_cnt_q;
    logic [10:0] uv_cnt_d;
    logic run_lvl;
    assign run_lvl = soft_start_ref == 8'hff;
    assign uv_cnt_d = (fb_below_uv && run_lvl) ? uv_cnt_q + 11'h001 : 11'h000;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            uv_cnt_q <= 11'h000;
        end else begin
            uv_cnt_q <= uv_cnt_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence bus_req_s; $rose(avs_read || avs_write); endsequence
    sequence ov_run_s; (fb_above_ov && run_lvl) [*8]; endsequence
    sequence halted_s; (!enable_pin || !logic_supply_ok) [*8]; endsequence
    bus_wait_a: assert property (
        bus_req_s |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait state count wrong");
    ramp_step_a: assert property (
        soft_start_ref != $past(soft_start_ref) |->
        soft_start_ref == $past(soft_start_ref) + 8'h01 ||
        soft_start_ref == 8'h00) else $error("ramp jumped");
    prebias_block_a: assert property (
        (fb_above_ramp && !run_lvl && soft_start_ref != 8'h00) [*8] |->
        !high_side_switch && !low_side_switch)
        else $error("switching while above ramp");
    valley_skip_a: assert property (
        (valley_over_limit && !fb_above_ramp && soft_start_ref != 8'h00) [*8]
        |-> !high_side_switch && low_side_switch)
        else $error("valley limit ignored");
    ov_discharge_a: assert property (
        ov_run_s |-> !high_side_switch && low_side_switch)
        else $error("no overvoltage discharge");
    therm_off_a: assert property (
        temp_hot [*8] |-> !high_side_switch && !low_side_switch &&
        soft_start_ref == 8'h00) else $error("hot but switching");
    halt_idle_a: assert property (
        halted_s |-> !high_side_switch && !low_side_switch &&
        soft_start_ref == 8'h00) else $error("not idle when halted");
    pg_inside_a: assert property (
        fb_in_window [*8] |-> output_ok_oe_b)
        else $error("output-ok held low in window");
    pg_outside_a: assert property (
        (!fb_in_window) [*8] |-> !output_ok_oe_b && !output_ok_o)
        else $error("output-ok released outside window");
    uv_bound_a: assert property (
        UV_TRIP_EN |-> uv_cnt_q < 11'(UV_LIM))
        else $error("undervoltage trip late");
endmodule : bfss_top_properties
`default_nettype wire

// ### common/bfss_pkg.sv
// Constants and types for the buck fault and start-up supervisor
// Behaviour
// - Feedback under 0.45 V for 20 us trips
// - Undervoltage trip latches off until supply/enable recycle
// - Undervoltage trip armed only after soft-start
// - Build option removes undervoltage trip entirely
// - Feedback 21 % high: high off, low on
// - Leave discharge once feedback back at reference
// - Voltage protections inactive during soft-start
// - Current limit active during soft-start too
// - Valley over limit: skip high pulse, low on
// - Over 160 C: thermal trip, both off
// - Below 130 C: restart with full soft-start
// - Supply above lockout starts 1 ms ramp
// - Feedback above ramp during soft-start blocks all switching
// - Output-ok pulled low outside good window
package bfss_pkg;
    localparam int CLK_MHZ = 40;
    localparam int UV_QUAL_NS = 20000;
    localparam int UV_CNT_W = 10;
    // Least time, so round up
    localparam int UV_QUAL_INT = (UV_QUAL_NS * CLK_MHZ + 999) / 1000;
    localparam logic [UV_CNT_W-1:0] UV_QUAL_CYC = UV_CNT_W'(UV_QUAL_INT);
    localparam int SS_TIME_US = 1000;
    localparam int SS_CYC = SS_TIME_US * CLK_MHZ;
    localparam int RAMP_W = 8;
    localparam int RAMP_STEPS = 256;
    localparam logic [RAMP_W-1:0] RAMP_MAX = 8'hff;
    localparam int STEP_W = 16;

    // Avalon byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATE = 4'hc;

    // Event bits, shared by status and mask
    localparam int EV_UV = 0;
    localparam int EV_OV = 1;
    localparam int EV_OT = 2;
    localparam int EV_OC = 3;
    localparam int EV_PG = 4;
    localparam int EV_SS = 5;
    localparam int EV_W = 6;
    localparam logic [EV_W-1:0] MASK_RST = 6'h00;
    localparam int CTRL_OFF = 0;
    localparam logic CTRL_OFF_RST = 1'b0;

    // State readout fields
    localparam int ST_RAMP_LSB = 8;
    localparam int ST_HS = 16;
    localparam int ST_LS = 17;
    localparam int ST_PGPIN = 18;
    localparam int ST_RUNOK = 19;

    // Synchronised input vector positions
    localparam int IN_SUPPLY = 0;
    localparam int IN_EN = 1;
    localparam int IN_UV = 2;
    localparam int IN_OV = 3;
    localparam int IN_REF = 4;
    localparam int IN_RAMP = 5;
    localparam int IN_OC = 6;
    localparam int IN_HOT = 7;
    localparam int IN_COOL = 8;
    localparam int IN_WIN = 9;
    localparam int IN_PGPIN = 10;
    localparam int IN_W = 11;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SOFT = 6'h02,
        ST_RUN = 6'h04,
        ST_OVD = 6'h08,
        ST_UVL = 6'h10,
        ST_THERM = 6'h20
    } bfss_state_t;
endpackage : bfss_pkg

// ### common/bfss_sync_if.sv
// Raw and qualified input bundle between supervisor and synchroniser
`timescale 1ns/1ps
`default_nettype none
interface bfss_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : bfss_sync_if
`default_nettype wire

// ### logic/bfss_sync.sv
// Three-stage synchroniser with agreement qualification
`timescale 1ns/1ps
`default_nettype none
module bfss_sync #(
    parameter int W = 1
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Synchronous reset
    bfss_sync_if.sync port // Raw in, qualified out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] clean_q;
    logic [W-1:0] clean_d;

    assign clean_d = ((s2_q ^ s3_q) & clean_q) | (~(s2_q ^ s3_q) & s3_q);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            clean_q <= '0;
        end else begin
            s1_q <= port.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            clean_q <= clean_d;
        end
    end

    assign port.clean = clean_q;
endmodule : bfss_sync
`default_nettype wire

// ### logic/bfss_top.sv
// Buck converter start-up and fault supervisor with Avalon registers
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bfss_top #(
    parameter int SS_CYC = bfss_pkg::SS_CYC,
    parameter bit UV_TRIP_EN = 1'b1
) (
    input wire logic clk, // 40 MHz system clock
    input wire logic rst_b, // Synchronous reset
    input wire logic [bfss_pkg::ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    output logic irq, // Level interrupt
    input wire logic logic_supply_ok, // Supply above lockout
    input wire logic enable_pin, // Enable pin
    input wire logic fb_below_uv, // Feedback under 0.45 V
    input wire logic fb_above_ov, // Feedback over 121 %
    input wire logic fb_at_ref, // Feedback at or under 0.6 V
    input wire logic fb_above_ramp, // Feedback over ramp
    input wire logic valley_over_limit, // Valley over 7.5 A
    input wire logic temp_hot, // Junction over 160 C
    input wire logic temp_cool, // Junction under 130 C
    input wire logic fb_in_window, // Feedback in good window
    input wire logic hs_request, // On-time request, same clock
    output logic high_side_switch, // High-side enable
    output logic low_side_switch, // Low-side enable
    output logic [bfss_pkg::RAMP_W-1:0] soft_start_ref, // Ramp code
    input wire logic output_ok_i, // Output-ok pin level
    output logic output_ok_o, // Output-ok drive value
    output logic output_ok_oe_b // Output-ok drive, low drives
);
    localparam int STEP_RAW = SS_CYC / bfss_pkg::RAMP_STEPS;
    localparam int STEP_INT = (STEP_RAW < 1) ? 1 : STEP_RAW;
    localparam logic [bfss_pkg::STEP_W-1:0] STEP_LAST =
        bfss_pkg::STEP_W'(STEP_INT - 1);

    bfss_sync_if #(.W(bfss_pkg::IN_W)) sin ();

    bfss_sync #(.W(bfss_pkg::IN_W)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .port(sin.sync)
    );

    assign sin.raw[bfss_pkg::IN_SUPPLY] = logic_supply_ok;
    assign sin.raw[bfss_pkg::IN_EN] = enable_pin;
    assign sin.raw[bfss_pkg::IN_UV] = fb_below_uv;
    assign sin.raw[bfss_pkg::IN_OV] = fb_above_ov;
    assign sin.raw[bfss_pkg::IN_REF] = fb_at_ref;
    assign sin.raw[bfss_pkg::IN_RAMP] = fb_above_ramp;
    assign sin.raw[bfss_pkg::IN_OC] = valley_over_limit;
    assign sin.raw[bfss_pkg::IN_HOT] = temp_hot;
    assign sin.raw[bfss_pkg::IN_COOL] = temp_cool;
    assign sin.raw[bfss_pkg::IN_WIN] = fb_in_window;
    assign sin.raw[bfss_pkg::IN_PGPIN] = output_ok_i;

    wire supply_ok = sin.clean[bfss_pkg::IN_SUPPLY];
    wire enable_ok = sin.clean[bfss_pkg::IN_EN];
    wire fb_low = sin.clean[bfss_pkg::IN_UV];
    wire fb_high = sin.clean[bfss_pkg::IN_OV];
    wire fb_ref = sin.clean[bfss_pkg::IN_REF];
    wire fb_over_ramp = sin.clean[bfss_pkg::IN_RAMP];
    wire oc_now = sin.clean[bfss_pkg::IN_OC];
    wire hot = sin.clean[bfss_pkg::IN_HOT];
    wire cool = sin.clean[bfss_pkg::IN_COOL];
    wire in_win = sin.clean[bfss_pkg::IN_WIN];
    wire pg_pin = sin.clean[bfss_pkg::IN_PGPIN];

    bfss_pkg::bfss_state_t state_q;
    bfss_pkg::bfss_state_t state_d;
    logic [bfss_pkg::UV_CNT_W-1:0] uv_cnt_q;
    logic [bfss_pkg::UV_CNT_W-1:0] uv_cnt_d;
    logic [bfss_pkg::STEP_W-1:0] step_q;
    logic [bfss_pkg::STEP_W-1:0] step_d;
    logic [bfss_pkg::RAMP_W-1:0] ramp_q;
    logic [bfss_pkg::RAMP_W-1:0] ramp_d;
    logic hs_q;
    logic hs_d;
    logic ls_q;
    logic ls_d;
    logic pg_oe_b_q;
    logic oc_prev_q;
    logic win_prev_q;
    logic [bfss_pkg::EV_W-1:0] status_q;
    logic [bfss_pkg::EV_W-1:0] status_d;
    logic [bfss_pkg::EV_W-1:0] mask_q;
    logic ctrl_off_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Software shutdown behaves like the enable pin going low
    wire run_ok = supply_ok & enable_ok & ~ctrl_off_q;
    wire ramp_done = (ramp_q == bfss_pkg::RAMP_MAX);
    wire in_soft = (state_q == bfss_pkg::ST_SOFT);
    wire in_run = (state_q == bfss_pkg::ST_RUN);
    wire uv_armed = UV_TRIP_EN & in_run;
    wire uv_fire = uv_armed & (uv_cnt_q == bfss_pkg::UV_QUAL_CYC);
    wire step_tick = (step_q == STEP_LAST);

    // Sequencer
    always_comb begin
        state_d = state_q;
        if (!run_ok) begin
            state_d = bfss_pkg::ST_IDLE;
        end else begin
            case (state_q)
                bfss_pkg::ST_IDLE: begin
                    if (hot) begin
                        state_d = bfss_pkg::ST_THERM;
                    end else begin
                        state_d = bfss_pkg::ST_SOFT;
                    end
                end
                bfss_pkg::ST_SOFT: begin
                    if (hot) begin
                        state_d = bfss_pkg::ST_THERM;
                    end else if (ramp_done) begin
                        state_d = bfss_pkg::ST_RUN;
                    end
                end
                bfss_pkg::ST_RUN: begin
                    if (hot) begin
                        state_d = bfss_pkg::ST_THERM;
                    end else if (uv_fire) begin
                        state_d = bfss_pkg::ST_UVL;
                    end else if (fb_high) begin
                        state_d = bfss_pkg::ST_OVD;
                    end
                end
                bfss_pkg::ST_OVD: begin
                    if (hot) begin
                        state_d = bfss_pkg::ST_THERM;
                    end else if (fb_ref) begin
                        state_d = bfss_pkg::ST_RUN;
                    end
                end
                bfss_pkg::ST_UVL: begin
                    state_d = bfss_pkg::ST_UVL;
                end
                bfss_pkg::ST_THERM: begin
                    if (cool && !hot) begin
                        state_d = bfss_pkg::ST_SOFT;
                    end
                end
                default: begin
                    state_d = bfss_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Qualification restarts as soon as the feedback recovers
    always_comb begin
        uv_cnt_d = '0;
        if (uv_armed && fb_low) begin
            if (uv_cnt_q == bfss_pkg::UV_QUAL_CYC) begin
                uv_cnt_d = uv_cnt_q;
            end else begin
                uv_cnt_d = uv_cnt_q + 1'b1;
            end
        end
    end

    // Ramp restarts from zero on every entry into soft-start
    always_comb begin
        step_d = '0;
        ramp_d = ramp_q;
        if (in_soft) begin
            if (step_tick) begin
                if (!ramp_done) begin
                    ramp_d = ramp_q + 1'b1;
                end
            end else begin
                step_d = step_q + 1'b1;
            end
        end else if (!in_run && state_q != bfss_pkg::ST_OVD) begin
            ramp_d = '0;
        end
        if (!run_ok) begin
            ramp_d = '0;
        end
    end

    // Switch steering, based on the state being entered
    always_comb begin
        hs_d = 1'b0;
        ls_d = 1'b0;
        case (state_d)
            bfss_pkg::ST_SOFT, bfss_pkg::ST_RUN: begin
                if (in_soft && fb_over_ramp) begin
                    hs_d = 1'b0;
                    ls_d = 1'b0;
                end else if (oc_now) begin
                    hs_d = 1'b0;
                    ls_d = 1'b1;
                end else begin
                    hs_d = hs_request;
                    ls_d = ~hs_request;
                end
            end
            bfss_pkg::ST_OVD: begin
                hs_d = 1'b0;
                ls_d = 1'b1;
            end
            default: begin
                hs_d = 1'b0;
                ls_d = 1'b0;
            end
        endcase
    end

    // Events
    wire ev_uv = in_run & (state_d == bfss_pkg::ST_UVL);
    wire ev_ov = in_run & (state_d == bfss_pkg::ST_OVD);
    wire ev_ot = (state_q != bfss_pkg::ST_THERM)
                 & (state_d == bfss_pkg::ST_THERM);
    wire ev_oc = (in_soft | in_run) & oc_now & ~oc_prev_q;
    wire ev_pg = win_prev_q & ~in_win;
    wire ev_ss = in_soft & (state_d == bfss_pkg::ST_RUN);
    wire [bfss_pkg::EV_W-1:0] events = {ev_ss, ev_pg, ev_oc, ev_ot, ev_ov,
                                        ev_uv};

    // Bus decode
    wire bus_req = avs_read | avs_write;
    wire bus_first = bus_req & ~ack_q;
    wire bus_take = bus_req & ack_q;
    wire sel_status = (avs_address == bfss_pkg::REG_STATUS);
    wire sel_mask = (avs_address == bfss_pkg::REG_MASK);
    wire sel_ctrl = (avs_address == bfss_pkg::REG_CTRL);
    wire sel_state = (avs_address == bfss_pkg::REG_STATE);
    wire wr_mask = bus_take & avs_write & sel_mask;
    wire wr_ctrl = bus_take & avs_write & sel_ctrl;
    wire rd_status = bus_take & avs_read & sel_status;

    wire [31:0] state_word = {
        12'h000,
        run_ok,
        pg_pin,
        ls_q,
        hs_q,
        ramp_q,
        2'h0,
        state_q
    };

    always_comb begin
        rdata_d = rdata_q;
        if (bus_first && avs_read) begin
            if (sel_status) begin
                rdata_d = {26'h0000000, status_q};
            end else if (sel_mask) begin
                rdata_d = {26'h0000000, mask_q};
            end else if (sel_ctrl) begin
                rdata_d = {31'h00000000, ctrl_off_q};
            end else if (sel_state) begin
                rdata_d = state_word;
            end else begin
                rdata_d = 32'h00000000;
            end
        end
    end

    // Only bits reported by this read clear; new events win
    always_comb begin
        status_d = status_q;
        if (rd_status) begin
            status_d = status_q & ~rdata_q[bfss_pkg::EV_W-1:0];
        end
        status_d = status_d | events;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= bfss_pkg::ST_IDLE;
            uv_cnt_q <= '0;
            step_q <= '0;
            ramp_q <= '0;
        end else begin
            state_q <= state_d;
            uv_cnt_q <= uv_cnt_d;
            step_q <= step_d;
            ramp_q <= ramp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hs_q <= 1'b0;
            ls_q <= 1'b0;
            pg_oe_b_q <= 1'b0;
            oc_prev_q <= 1'b0;
            win_prev_q <= 1'b0;
        end else begin
            hs_q <= hs_d;
            ls_q <= ls_d;
            pg_oe_b_q <= in_win;
            oc_prev_q <= oc_now;
            win_prev_q <= in_win;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_q <= '0;
            mask_q <= bfss_pkg::MASK_RST;
            ctrl_off_q <= bfss_pkg::CTRL_OFF_RST;
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            status_q <= status_d;
            if (wr_mask) begin
                mask_q <= avs_writedata[bfss_pkg::EV_W-1:0];
            end
            if (wr_ctrl) begin
                ctrl_off_q <= avs_writedata[bfss_pkg::CTRL_OFF];
            end
            ack_q <= bus_first;
            rdata_q <= rdata_d;
        end
    end

    // One wait state keeps the read mux out of the bus path
    assign avs_waitrequest = bus_req & ~ack_q;
    assign avs_readdata = rdata_q;
    assign irq = |(status_q & mask_q);
    assign high_side_switch = hs_q;
    assign low_side_switch = ls_q;
    assign soft_start_ref = ramp_q;
    // Open drain: only ever pulls low, the board supplies the high
    assign output_ok_o = 1'b0;
    assign output_ok_oe_b = pg_oe_b_q;
endmodule : bfss_top
`default_nettype wire
